// >>> rtl/nsapr_pkg.sv
// Package for the non-secure access permission register block
package nsapr_pkg;

	// ****************************************
	// Register selection and field layout
	// ****************************************
	localparam logic [2:0]  SEL_OPC1       = 3'h0;
	localparam logic [3:0]  SEL_PRIMARY    = 4'h1;
	localparam logic [3:0]  SEL_SECONDARY  = 4'h1;
	localparam logic [2:0]  SEL_OPC2       = 3'h2;
	localparam int          FLD_DMA        = 18;
	localparam int          FLD_TLB_LOCK   = 17;
	localparam int          FLD_CACHE_LOCK = 16;
	localparam int          COPROC_COUNT   = 14;
	localparam logic [31:0] WRITABLE_MASK  = 32'h0007_3fff;
	localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;

	// Coprocessor transfer request from the core
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       privileged;
		logic [2:0] opc1;
		logic [3:0] primaryRegField;
		logic [3:0] secondaryRegField;
		logic [2:0] opc2;
		logic [31:0] wdata;
	} nsapr_req_t;

	// Answer to the core
	typedef struct packed {
		logic        done;
		logic        undefinedExc;
		logic [31:0] rdata;
	} nsapr_rsp_t;

	// Decoded permissions to consumers
	typedef struct packed {
		logic        dmaNonsecure;
		logic        tlbLockShare;
		logic        cacheLockShare;
		logic [13:0] coprocNonsecurePermit;
	} nsapr_perm_t;

	// Whole state of the block
	typedef struct packed {
		logic [31:0] perm;
		nsapr_rsp_t  rsp;
	} nsapr_state_t;

endpackage

// >>> rtl/nsapr_reg.sv
// Non-secure access permission register with access checking
`timescale 1ns/1ps

module nsapr_reg
	import nsapr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire nsapr_req_t  req,
	input  wire logic        worldSelect,
	input  wire logic        tlbInvAll,
	input  wire logic        tlbEntryLocked,
	output nsapr_rsp_t       rsp,
	output nsapr_perm_t      perm,
	output logic             tlbInvHitAllowed
);

	// ****************************************
	// Decode helpers
	// ****************************************
	// Full address match of the transfer fields
	function automatic logic selects(input nsapr_req_t r);
		return r.opc1 == SEL_OPC1 && r.primaryRegField == SEL_PRIMARY &&
			r.secondaryRegField == SEL_SECONDARY && r.opc2 == SEL_OPC2;
	endfunction

	nsapr_state_t state_reg;
	nsapr_state_t state_next;
	logic         hit;
	logic         nonSecure;
	logic         secureWrite;
	// One flat vector of coprocessor grants, filled bit by bit below
	logic [COPROC_COUNT-1:0] coprocPermit;

	// A transfer that misses any selector field belongs to another register
	assign hit       = req.valid && selects(req);
	assign nonSecure = worldSelect;

	// ****************************************
	// Access classification
	// ****************************************
	// Only a Secure privileged write may alter the stored grants
	assign secureWrite = hit && req.privileged && req.write && !nonSecure;

	// ****************************************
	// Next state
	// ****************************************
	// Access is refused before any storing, so a refused write never leaks in
	always_comb begin
		state_next      = state_reg;
		state_next.rsp  = '0;
		if (hit) begin
			state_next.rsp.done = 1'b1;
			if (!req.privileged) begin
				state_next.rsp.undefinedExc = 1'b1;
			end else if (req.write) begin
				if (nonSecure) begin
					state_next.rsp.undefinedExc = 1'b1;
				end else begin
					state_next.perm = req.wdata & WRITABLE_MASK;
				end
			end else begin
				state_next.rsp.rdata = state_reg.perm & WRITABLE_MASK;
			end
		end
	end

	// Register the whole state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg.perm <= RESET_VALUE;
			state_reg.rsp  <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// Outputs to consumers
	// ****************************************
	assign rsp                        = state_reg.rsp;
	assign perm.dmaNonsecure          = state_reg.perm[FLD_DMA];
	assign perm.tlbLockShare          = state_reg.perm[FLD_TLB_LOCK];
	assign perm.cacheLockShare        = state_reg.perm[FLD_CACHE_LOCK];
	assign perm.coprocNonsecurePermit = coprocPermit;
	// One grant line per coprocessor, so the bit number is the coprocessor number
	for (genvar n = 0; n < COPROC_COUNT; n++) begin : g_coproc
		assign coprocPermit[n] = state_reg.perm[n];
	end
	// Invalidate-all must not remove locked entries
	assign tlbInvHitAllowed = !(tlbInvAll && tlbEntryLocked);

	// ****************************************
	// Assertions
	// ****************************************
	property p_user_undef;
		@(posedge clock) disable iff (!resetn)
		hit && !req.privileged |=> rsp.undefinedExc && rsp.done;
	endproperty
	a_user_undef: assert property (p_user_undef) else $error("User access not refused");

	property p_nonsec_wr;
		@(posedge clock) disable iff (!resetn)
		hit && req.privileged && req.write && worldSelect |=> rsp.undefinedExc && $stable(perm);
	endproperty
	a_nonsec_wr: assert property (p_nonsec_wr) else $error("Non-secure write not refused");

	property p_s_write;
		@(posedge clock) disable iff (!resetn)
		hit && req.privileged && req.write && !worldSelect
			|=> state_reg.perm == ($past(req.wdata) & WRITABLE_MASK) && !rsp.undefinedExc;
	endproperty
	a_s_write: assert property (p_s_write) else $error("Secure write not stored");

	property p_read_data;
		@(posedge clock) disable iff (!resetn)
		hit && req.privileged && !req.write |=> rsp.rdata == state_reg.perm && !rsp.undefinedExc;
	endproperty
	a_read_data: assert property (p_read_data) else $error("Read data wrong");

	property p_reserved_zero;
		@(posedge clock) disable iff (!resetn)
		(state_reg.perm & ~WRITABLE_MASK) == 32'h0 && (rsp.rdata & ~WRITABLE_MASK) == 32'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set");

	property p_no_hit_quiet;
		@(posedge clock) disable iff (!resetn)
		!hit |=> !rsp.done && $stable(state_reg.perm);
	endproperty
	a_no_hit_quiet: assert property (p_no_hit_quiet) else $error("Unselected access acted");

	property p_fields;
		@(posedge clock) disable iff (!resetn)
		perm.dmaNonsecure == state_reg.perm[18] && perm.tlbLockShare == state_reg.perm[17]
			&& perm.cacheLockShare == state_reg.perm[16];
	endproperty
	a_fields: assert property (p_fields) else $error("Field output wrong");

	property p_inv_all;
		@(posedge clock) disable iff (!resetn)
		tlbInvAll && tlbEntryLocked |-> !tlbInvHitAllowed;
	endproperty
	a_inv_all: assert property (p_inv_all) else $error("Invalidate-all hit locked entry");

	property p_reset_zero;
		@(posedge clock) $rose(resetn) |-> state_reg.perm == 32'h0;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("Reset value not zero");

	// Every selected transfer is answered on the next edge
	property p_hit_answered;
		@(posedge clock) disable iff (!resetn)
		hit |=> rsp.done;
	endproperty
	a_hit_answered: assert property (p_hit_answered) else $error("Selected access unanswered");

	// No exception and no data may show without an answer
	property p_idle_rsp;
		@(posedge clock) disable iff (!resetn)
		!rsp.done |-> !rsp.undefinedExc && rsp.rdata == 32'h0;
	endproperty
	a_idle_rsp: assert property (p_idle_rsp) else $error("Answer field without done");

	// An exception always comes as an answer, never on its own
	property p_undef_done;
		@(posedge clock) disable iff (!resetn)
		rsp.undefinedExc |-> rsp.done;
	endproperty
	a_undef_done: assert property (p_undef_done) else $error("Lone exception");

	// User mode gets neither the contents nor a change of them
	property p_user_keep;
		@(posedge clock) disable iff (!resetn)
		hit && !req.privileged |=> $stable(state_reg.perm) && rsp.rdata == 32'h0;
	endproperty
	a_user_keep: assert property (p_user_keep) else $error("User access leaked");

	// A write answers with no read data
	property p_write_nodata;
		@(posedge clock) disable iff (!resetn)
		hit && req.write |=> rsp.rdata == 32'h0;
	endproperty
	a_write_nodata: assert property (p_write_nodata) else $error("Write returned data");

	// The grants change only after an accepted Secure privileged write
	property p_sec_only;
		@(posedge clock) disable iff (!resetn)
		$changed(state_reg.perm) |-> $past(secureWrite);
	endproperty
	a_sec_only: assert property (p_sec_only) else $error("Grants changed unasked");

	// Coprocessor n is granted by bit n and by nothing else
	property p_coproc_field;
		@(posedge clock) disable iff (!resetn)
		perm.coprocNonsecurePermit == state_reg.perm[13:0];
	endproperty
	a_coproc_field: assert property (p_coproc_field) else $error("Coprocessor grant wrong");

	// Single-entry and identifier invalidates, and any unlocked entry, may always be hit
	property p_other_inv;
		@(posedge clock) disable iff (!resetn)
		!(tlbInvAll && tlbEntryLocked) |-> tlbInvHitAllowed;
	endproperty
	a_other_inv: assert property (p_other_inv) else $error("Invalidate wrongly blocked");

	// Main scenarios that the tests are expected to reach
	c_s_write:      cover property (@(posedge clock) hit && req.write && req.privileged && !worldSelect);
	c_nonsec_read:  cover property (@(posedge clock) hit && !req.write && req.privileged && worldSelect);
	c_nonsec_write: cover property (@(posedge clock) hit && req.write && req.privileged && worldSelect);
	c_user:         cover property (@(posedge clock) hit && !req.privileged);
	c_inv_filter:   cover property (@(posedge clock) tlbInvAll && tlbEntryLocked);

endmodule // nsapr_reg

// >>> verification/nsapr_core_model.sv
// Core model issuing coprocessor register transfers to the block
`timescale 1ns/1ps

module nsapr_core_model
	import nsapr_pkg::*;
(
	input  wire logic       clock,
	input  wire nsapr_rsp_t rsp,
	output nsapr_req_t      req,
	output logic            worldSelect
);
	// Idle until the first transfer
	initial begin
		req = '0;
		worldSelect = 1'b0;
	end

	// One transfer: held up to the answering edge, then released
	task automatic xfer(input logic w, input logic p, input logic nonsec, input logic [2:0] o2,
		input logic [31:0] d, output nsapr_rsp_t r);
		@(posedge clock);
		#1;
		worldSelect = nonsec;
		req = '{1'b1, w, p, SEL_OPC1, SEL_PRIMARY, SEL_SECONDARY, o2, d};
		@(posedge clock);
		#1;
		r = rsp;
		req.valid = 1'b0;
		req.wdata = ~d; // Stale payload is inverted so it never passes for data
	endtask
endmodule // nsapr_core_model

// >>> verification/nsapr_reg_tb.sv
// Self-checking testbench for the permission register block
`timescale 1ns/1ps

module nsapr_reg_tb
	import nsapr_pkg::*;
;
	logic        clock, resetn, tlbInvAll, tlbEntryLocked, tlbInvHitAllowed, worldSelect;
	nsapr_req_t  req;
	nsapr_rsp_t  rsp;
	nsapr_perm_t perm;
	int          failures, comparisons;
	logic [31:0] vals [4] = '{32'h0004_0000, 32'h0002_0000, 32'h0001_0000, 32'h0000_2001};

	nsapr_reg nsapr_reg_inst (.clock(clock), .resetn(resetn), .req(req),
		.worldSelect(worldSelect), .tlbInvAll(tlbInvAll), .tlbEntryLocked(tlbEntryLocked),
		.rsp(rsp), .perm(perm), .tlbInvHitAllowed(tlbInvHitAllowed));
	nsapr_core_model nsapr_core_model_inst (.clock(clock), .rsp(rsp), .req(req),
		.worldSelect(worldSelect));

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One transfer with expected done/undefined pair and read data
	task automatic acc(input logic w, input logic p, input logic nonsec, input logic [2:0] o2,
		input logic [31:0] d, input logic [1:0] expRsp, input logic [31:0] expData);
		nsapr_rsp_t r;
		nsapr_core_model_inst.xfer(w, p, nonsec, o2, d, r);
		chk({30'h0, r.done, r.undefinedExc}, {30'h0, expRsp});
		chk(r.rdata, expData);
		// The answer stands for one cycle only
		@(posedge clock);
		#1 chk({31'h0, rsp.done}, 32'h0);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Clock at 125 MHz
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Watchdog, far beyond the roughly 60 cycles the tests need
	initial begin
		#20000;
		failures++;
		print_verdict();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		resetn = 1'b0;
		tlbInvAll = 1'b0;
		tlbEntryLocked = 1'b0;
		failures = 0;
		comparisons = 0;
		repeat (6) @(posedge clock);
		#1 resetn = 1'b1;
		chk({15'h0, perm}, 32'h0);
		acc(1'b0, 1'b1, 1'b0, SEL_OPC2, 32'h0, 2'b10, 32'h0);
		$display("Test reset values done");
		acc(1'b1, 1'b1, 1'b0, SEL_OPC2, 32'hffff_ffff, 2'b10, 32'h0);
		acc(1'b0, 1'b1, 1'b0, SEL_OPC2, 32'h0, 2'b10, 32'h0007_3fff);
		acc(1'b0, 1'b1, 1'b1, SEL_OPC2, 32'h0, 2'b10, 32'h0007_3fff);
		acc(1'b1, 1'b1, 1'b1, SEL_OPC2, 32'h0, 2'b11, 32'h0);
		// User mode in both worlds, reads and writes
		for (int i = 0; i < 4; i++)
			acc(i[0], 1'b0, i[1], SEL_OPC2, 32'h0, 2'b11, 32'h0);
		acc(1'b1, 1'b1, 1'b0, 3'h1, 32'h0, 2'b00, 32'h0);
		acc(1'b0, 1'b1, 1'b0, SEL_OPC2, 32'h0, 2'b10, 32'h0007_3fff);
		$display("Test access checking done");
		// Each permission field on its own
		foreach (vals[k]) begin
			acc(1'b1, 1'b1, 1'b0, SEL_OPC2, vals[k], 2'b10, 32'h0);
			chk({15'h0, perm}, {15'h0, vals[k][18:16], vals[k][13:0]});
		end
		$display("Test permission fields done");
		// Invalidate-all must spare locked entries
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			#1;
			tlbInvAll = i[0];
			tlbEntryLocked = i[1];
			#1 chk({31'h0, tlbInvHitAllowed}, {31'h0, ~(i[0] & i[1])});
		end
		$display("Test invalidate filter done");
		// A reset in mid-run must clear the grants stored above
		@(posedge clock);
		#1 resetn = 1'b0;
		repeat (2) @(posedge clock);
		#1 resetn = 1'b1;
		chk({15'h0, perm}, 32'h0);
		acc(1'b0, 1'b1, 1'b0, SEL_OPC2, 32'h0, 2'b10, 32'h0);
		$display("Test mid-run reset done");
		print_verdict();
	end
endmodule // nsapr_reg_tb
